// file: hw/fslr_map.svh
/*
 * Constants of the flash-security lockout-recovery block: register offsets,
 * status bit positions, reset values, test-port instruction codes and counts.
 * Assumes it is included by bare name in the design file, after the package.
 */
`ifndef FSLR_MAP_SVH
`define FSLR_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define FSLR_OFF_DIV      8'h00
`define FSLR_OFF_STATUS   8'h04
`define FSLR_OFF_KEY      8'h08

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define FSLR_DIV_RST        7'h00
`define FSLR_DIV_PRE_BIT    6
`define FSLR_ST_SECURE_BIT  0
`define FSLR_ST_BUSY_BIT    1
`define FSLR_ST_DONE_BIT    2
`define FSLR_ST_BACKDOOR_KEY_ENABLE_BIT   3
`define FSLR_ST_DBGSEL_BIT  4
`define FSLR_NV_BACKDOOR_KEY_ENABLE_BIT   15
`define FSLR_NV_UNSEC_CODE  2'h2

// ****************************************************************
// Test-port instruction codes and data register lengths
// ****************************************************************
`define FSLR_IR_SAMPLE    4'h1
`define FSLR_IR_IDCODE    4'h2
`define FSLR_IR_DEBUG     4'h6
`define FSLR_IR_LOCKOUT   4'h8
`define FSLR_IR_BYPASS    4'hF
`define FSLR_IR_CAPTURE   4'h1
`define FSLR_LEN_IDCODE   6'd32
`define FSLR_LEN_LOCKOUT  6'd7
`define FSLR_LEN_SAMPLE   6'd8
`define FSLR_LEN_BYPASS   6'd1

// ****************************************************************
// Timing counts
// ****************************************************************
`define FSLR_ERASE_TICKS  20000
`define FSLR_PRE_LAST     3'h7

`endif

// file: hw/fslr_pkg.sv
/*
 * Types of the flash-security lockout-recovery block.
 * Assumes nothing of its surroundings; constants live in fslr_map.svh.
 */
package fslr_pkg;

  // ****************************************************************
  // Test access port controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    TAP_TLR    = 4'b0000,
    TAP_RTI    = 4'b0001,
    TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011,
    TAP_SH_DR  = 4'b0100,
    TAP_EX1_DR = 4'b0101,
    TAP_PA_DR  = 4'b0110,
    TAP_EX2_DR = 4'b0111,
    TAP_UPD_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001,
    TAP_CAP_IR = 4'b1010,
    TAP_SH_IR  = 4'b1011,
    TAP_EX1_IR = 4'b1100,
    TAP_PA_IR  = 4'b1101,
    TAP_EX2_IR = 4'b1110,
    TAP_UPD_IR = 4'b1111
  } fslr_tap_e;

  typedef logic [3:0] fslr_ir_t;
  typedef logic [1:0] fslr_rsel_t;

endpackage

// file: hw/fslr_top.sv
/*
 * Flash-security interlock and lockout-recovery path behind the test port,
 * with an AHB-Lite register slave for the flash timing divisor and status.
 * Assumes test-port pins and flash strap inputs are synchronous to hclk and
 * that tck runs well below hclk/2 so both of its edges are seen.
 */
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

`include "fslr_map.svh"

module fslr_top
  import fslr_pkg::*;
#(
  parameter int          ERASE_TICKS = `FSLR_ERASE_TICKS,
  parameter logic [31:0] IDCODE_VAL  = 32'h0ABC_D001  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Test port pins
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  input  wire logic        trst_n,
  output logic             tdo,
  output logic             tdo_oe,
  // Flash module side
  input  wire logic [15:0] nv_sec_bytes,
  input  wire logic [31:0] nv_backdoor_key,
  input  wire logic [7:0]  bsc_in,
  output logic             flash_mass_erase,
  output logic             flash_timing_clk,
  // Core debug side
  output logic             debug_read_disable,
  output logic             extended_debug_port_sel
);

  // ****************************************************************
  // Decoders
  // ****************************************************************
  function automatic fslr_rsel_t reg_sel(input logic [7:0] a);
    case (a)
      `FSLR_OFF_DIV:    reg_sel = 2'h0;
      `FSLR_OFF_STATUS: reg_sel = 2'h1;
      `FSLR_OFF_KEY:    reg_sel = 2'h2;
      default:          reg_sel = 2'h3;
    endcase
  endfunction
  function automatic logic [5:0] dr_len(input fslr_ir_t ir);
    case (ir)
      `FSLR_IR_IDCODE:  dr_len = `FSLR_LEN_IDCODE;
      `FSLR_IR_LOCKOUT: dr_len = `FSLR_LEN_LOCKOUT;
      `FSLR_IR_SAMPLE:  dr_len = `FSLR_LEN_SAMPLE;
      default:          dr_len = `FSLR_LEN_BYPASS;
    endcase
  endfunction
  function automatic fslr_tap_e tap_next(input fslr_tap_e s, input logic m);
    case (s)
      TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      default:    tap_next = TAP_TLR;
    endcase
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  fslr_tap_e   tap_q;
  fslr_ir_t    ir_q, ir_sh_q;
  logic [31:0] dr_q, dr_sh_d, hrdata_q, status_w;
  logic [15:0] tick_cnt_q;
  logic [7:0]  wr_addr_q;
  logic [6:0]  lock_div_q, flash_timing_clock_divisor_reg_q, eff_div;
  logic [5:0]  div_cnt_q;
  logic [2:0]  pre_cnt_q;
  logic        tck_q, tck_rise, tck_fall, tdo_q, tdo_oe_q;
  logic        lock_armed_q, pre_tick, div_hit, fclk_q, fclk_rise;
  logic        busy_q, done_q, erase_start, erase_end, load_done_q;
  logic        secure_q, backdoor_key_enable_q, nv_secured, key_hit;
  logic        dbg_dis_q, ext_dbg_q, wr_pend_q, hready_q, hresp_q, addr_ok;

  // ****************************************************************
  // Test access port controller
  // ****************************************************************
  // Inputs are synchronous, so tck is simply edge-detected in hclk
  assign tck_rise = tck & ~tck_q;
  assign tck_fall = ~tck & tck_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_q <= TAP_TLR;
    end else if (!trst_n) begin
      tap_q <= TAP_TLR;
    end else if (tck_rise) begin
      tap_q <= tap_next(tap_q, tms);
    end
  end
  // Instruction register: ID selected after boot and after port reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_q    <= `FSLR_IR_IDCODE;
      ir_sh_q <= `FSLR_IR_CAPTURE;
    end else if (!trst_n || tap_q == TAP_TLR) begin
      ir_q    <= `FSLR_IR_IDCODE;
      ir_sh_q <= `FSLR_IR_CAPTURE;
    end else if (tck_rise && tap_q == TAP_CAP_IR) begin
      ir_sh_q <= `FSLR_IR_CAPTURE;
    end else if (tck_rise && tap_q == TAP_SH_IR) begin
      ir_sh_q <= {tdi, ir_sh_q[3:1]};
    end else if (tck_fall && tap_q == TAP_UPD_IR) begin
      ir_q    <= ir_sh_q;
    end
  end
  always_comb begin
    dr_sh_d                 = {1'b0, dr_q[31:1]};
    dr_sh_d[dr_len(ir_q)-1] = tdi;
  end
  // Data registers share one shifter; the recovery register captures status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_q <= 32'h0000_0000;
    end else if (tck_rise && tap_q == TAP_CAP_DR) begin
      case (ir_q)
        `FSLR_IR_IDCODE:  dr_q <= IDCODE_VAL;
        `FSLR_IR_LOCKOUT: dr_q <= {29'h0, done_q, busy_q, secure_q};
        `FSLR_IR_SAMPLE:  dr_q <= {24'h0, bsc_in};
        default:          dr_q <= 32'h0000_0000;
      endcase
    end else if (tck_rise && tap_q == TAP_SH_DR) begin
      dr_q <= dr_sh_d;
    end
  end
  // Divider value loaded at Update-DR arms the erase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_div_q   <= `FSLR_DIV_RST;
      lock_armed_q <= 1'b0;
    end else if (!trst_n) begin
      lock_armed_q <= 1'b0;
    end else if (tck_fall && tap_q == TAP_UPD_DR && ir_q == `FSLR_IR_LOCKOUT) begin
      lock_div_q   <= dr_q[6:0];
      lock_armed_q <= 1'b1;
    end else if (erase_start) begin
      lock_armed_q <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q    <= (tap_q == TAP_SH_IR) ? ir_sh_q[0] : dr_q[0];
      tdo_oe_q <= (tap_q == TAP_SH_IR) || (tap_q == TAP_SH_DR);
    end
  end

  // ****************************************************************
  // Flash timing clock divider
  // ****************************************************************
  // The recovery value wins only while erasing, so software settings survive
  assign eff_div   = busy_q ? lock_div_q : flash_timing_clock_divisor_reg_q;
  assign pre_tick  = ~eff_div[`FSLR_DIV_PRE_BIT] | (pre_cnt_q == `FSLR_PRE_LAST);
  assign div_hit   = pre_tick && (div_cnt_q >= eff_div[5:0]);
  assign fclk_rise = div_hit && !fclk_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_q <= 3'h0;
      div_cnt_q <= 6'h00;
      fclk_q    <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 3'h1;
      if (div_hit) begin
        div_cnt_q <= 6'h00;
        fclk_q    <= ~fclk_q;
      end else if (pre_tick) begin
        div_cnt_q <= div_cnt_q + 6'h01;
      end
    end
  end

  // ****************************************************************
  // Lockout erase sequencer
  // ****************************************************************
  assign erase_start = (tap_q == TAP_RTI) && (ir_q == `FSLR_IR_LOCKOUT)
                       && lock_armed_q && !busy_q && !done_q;
  assign erase_end   = busy_q && fclk_rise
                       && (tick_cnt_q == 16'(ERASE_TICKS - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      tick_cnt_q <= 16'h0000;
    end else if (erase_start) begin
      busy_q     <= 1'b1;
      tick_cnt_q <= 16'h0000;
    end else if (busy_q && tap_q != TAP_RTI) begin
      busy_q     <= 1'b0;  // Leaving Run-Test/Idle abandons the erase
    end else if (erase_end) begin
      busy_q     <= 1'b0;
      done_q     <= 1'b1;
    end else if (busy_q && fclk_rise) begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Security state
  // ****************************************************************
  assign nv_secured = (nv_sec_bytes[1:0] != `FSLR_NV_UNSEC_CODE);
  assign key_hit    = wr_pend_q && (reg_sel(wr_addr_q) == 2'h2)
                      && backdoor_key_enable_q && (hwdata == nv_backdoor_key);
  // Secure until the strap is read, so debug never opens during reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_done_q           <= 1'b0;
      secure_q              <= 1'b1;
      backdoor_key_enable_q <= 1'b0;
    end else if (!load_done_q) begin
      load_done_q           <= 1'b1;
      secure_q              <= nv_secured;
      backdoor_key_enable_q <= nv_sec_bytes[`FSLR_NV_BACKDOOR_KEY_ENABLE_BIT];
    end else if (erase_end || key_hit) begin
      secure_q              <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_dis_q <= 1'b1;
      ext_dbg_q <= 1'b0;
    end else begin
      dbg_dis_q <= secure_q;
      ext_dbg_q <= (ir_q == `FSLR_IR_DEBUG) && !secure_q;
    end
  end

  // ****************************************************************
  // AHB-Lite register slave
  // ****************************************************************
  assign addr_ok  = hsel && htrans[1] && hready;
  assign status_w = {27'h0, ext_dbg_q, backdoor_key_enable_q, done_q, busy_q, secure_q};
  // Zero wait states: read data is fetched at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
      hrdata_q  <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        case (reg_sel(haddr[7:0]))
          2'h0:    hrdata_q <= {25'h0, flash_timing_clock_divisor_reg_q};
          2'h1:    hrdata_q <= status_w;
          default: hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_timing_clock_divisor_reg_q <= `FSLR_DIV_RST;
    end else if (wr_pend_q && reg_sel(wr_addr_q) == 2'h0) begin
      flash_timing_clock_divisor_reg_q <= hwdata[6:0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hreadyout               = hready_q;
  assign hresp                   = hresp_q;
  assign hrdata                  = hrdata_q;
  assign tdo                     = tdo_q;
  assign tdo_oe                  = tdo_oe_q;
  assign flash_mass_erase        = busy_q;
  assign flash_timing_clk        = fclk_q;
  assign debug_read_disable      = dbg_dis_q;
  assign extended_debug_port_sel = ext_dbg_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  port_reset_a: assert property (!trst_n |=> tap_q == TAP_TLR && ir_q == `FSLR_IR_IDCODE)
    else $error("test port not reset to ID selection");
  strap_load_a: assert property (!load_done_q |=> secure_q == $past(nv_secured))
    else $error("security not taken from strap bytes");
  debug_block_a: assert property (secure_q [*2] |-> dbg_dis_q && !ext_dbg_q)
    else $error("debug access open while secured");
  erase_start_a: assert property (erase_start |=> busy_q && !lock_armed_q)
    else $error("erase did not start in Run-Test/Idle");
  div_select_a: assert property (busy_q |-> eff_div == lock_div_q)
    else $error("erase not timed by recovery divider");
  prescale_map_a: assert property ($changed(fclk_q) |-> $past(div_cnt_q) >= $past(eff_div[5:0])
                                   && ($past(pre_cnt_q) == `FSLR_PRE_LAST || !$past(eff_div[6])))
    else $error("timing clock toggled off the divider count");
  erase_done_a: assert property ($rose(done_q) |-> !secure_q && !busy_q && !flash_mass_erase)
    else $error("erase completion left device secured");
  key_gate_a: assert property (load_done_q && secure_q && !busy_q && !backdoor_key_enable_q
                               |=> secure_q)
    else $error("unsecured by key while key disabled");
  erase_abort_a: assert property (busy_q && tap_q != TAP_RTI |=> !busy_q && !done_q)
    else $error("erase kept running outside Run-Test/Idle");
  erase_run_c: cover property (erase_start ##[1:1000] busy_q);
  erase_done_c: cover property ($rose(done_q));
  key_unlock_c: cover property (key_hit);
  idcode_cap_c: cover property (tck_rise && tap_q == TAP_CAP_DR && ir_q == `FSLR_IR_IDCODE);

endmodule // fslr_top

// file: verif/fslr_host.sv
/*
 * Test port host model: drives tck, tms, tdi and trst_n one bit at a time.
 * Assumes hclk is the system clock on which the block samples the port pins.
 */
`timescale 1ns/1ps
module fslr_host (
  // System clock
  input  wire logic hclk,
  // Test port
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // ****************************************************************
  // Bit and scan sequences
  // ****************************************************************
  // Each tck level spans at least two hclk edges so the port sees both edges
  task automatic bit_io(input logic m, input logic d, output logic o);
    @(posedge hclk);
    tms <= m;
    tdi <= d;
    repeat (2) @(posedge hclk);
    o = tdo;
    tck <= 1'b1;
    repeat (2) @(posedge hclk);
    tck <= 1'b0;
    @(posedge hclk);
    tdi <= ~d;  // Released data line never keeps the last bit
  endtask

  // Starts and ends in Run-Test/Idle; tck stands still on return
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    bit_io(1'b1, 1'b0, o);
    if (ir)
      bit_io(1'b1, 1'b0, o);
    bit_io(1'b0, 1'b0, o);
    bit_io(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], o);
      dout[i] = o;
    end
    bit_io(1'b1, 1'b0, o);
    bit_io(1'b0, 1'b0, o);  // Park in Run-Test/Idle after update
  endtask

  task automatic tap_reset();
    logic o;
    @(posedge hclk);
    trst_n <= 1'b0;
    repeat (2) @(posedge hclk);
    trst_n <= 1'b1;
    bit_io(1'b0, 1'b0, o);
  endtask
endmodule  // fslr_host

// file: verif/fslr_top_bench.sv
/*
 * Self-checking bench: register bus, security interlock, backdoor key,
 * timing divisor and the lockout erase with its abort.
 * Assumes the design files and fslr_host are compiled first.
 */
`timescale 1ns/1ps
`include "fslr_map.svh"
module fslr_top_bench;
  localparam int          TICKS = 4;
  localparam logic [31:0] IDV   = 32'h1357_9BDF;  // Arbitrary value
  localparam logic [31:0] KEY   = 32'h2468_ACE1;
  localparam logic [31:0] A_DIV = 32'(`FSLR_OFF_DIV);
  localparam logic [31:0] A_ST  = 32'(`FSLR_OFF_STATUS);
  localparam logic [31:0] A_KEY = 32'(`FSLR_OFF_KEY);
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        tck, tms, tdi, trst_n, tdo, toe, erase, tclk, drd, dsel;
  logic        oe_seen = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd, dout;
  logic [1:0]  htrans;
  logic [15:0] nv;
  int          n_mismatch, checks, p, k;

  fslr_top #(.ERASE_TICKS(TICKS), .IDCODE_VAL(IDV)) i_fslr_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(toe), .nv_sec_bytes(nv),
    .nv_backdoor_key(KEY), .bsc_in(8'h5A), .flash_mass_erase(erase),
    .flash_timing_clk(tclk), .debug_read_disable(drd), .extended_debug_port_sel(dsel));
  fslr_host i_fslr_host (
    .hclk(hclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

  assign hready = hreadyout;

  // Remembers that the block drove tdo at some point of a shift
  always @(posedge hclk) begin
    if (toe === 1'b1)
      oe_seen <= 1'b1;
  end

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst(input logic [15:0] v);
    @(posedge hclk);
    hresetn <= 1'b0;
    nv <= v;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    i_fslr_host.tap_reset();
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic per();
    time t0;
    @(posedge tclk);
    t0 = $time;
    @(posedge tclk);
    p = int'(($time - t0) / 100);
    @(posedge hclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_boot();
    chk("hresp", 32'(hresp), 32'h0);
    chk("hready", 32'(hreadyout), 32'h1);
    chk("erase idle", 32'(erase), 32'h0);
    chk("read disable", 32'(drd), 32'h1);
    ahb(1'b0, A_ST, 32'h0);
    chk("status secure", rd, 32'h1);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    i_fslr_host.scan(1'b0, 32, 32'h0, dout);
    chk("idcode", dout, IDV);
    chk("tdo drive seen", 32'(oe_seen), 32'h1);
    chk("tdo released", 32'(toe), 32'h0);
    i_fslr_host.scan(1'b1, 4, 32'(`FSLR_IR_SAMPLE), dout);
    i_fslr_host.scan(1'b0, 8, 32'h0, dout);
    chk("boundary sample", dout, 32'h5A);
    i_fslr_host.scan(1'b1, 4, 32'(`FSLR_IR_DEBUG), dout);
    chk("ir capture", dout, 32'(`FSLR_IR_CAPTURE));
    chk("debug sel secured", 32'(dsel), 32'h0);
    $display("test boot done");
  endtask

  task automatic t_key();
    ahb(1'b1, A_KEY, KEY);
    ahb(1'b0, A_ST, 32'h0);
    chk("key disabled", rd, 32'h1);
    rst(16'h8000);  // Key stands before the security bytes load
    ahb(1'b1, A_KEY, ~KEY);
    ahb(1'b0, A_ST, 32'h0);
    chk("wrong key", rd, 32'h9);
    ahb(1'b1, A_KEY, KEY);
    repeat (2) @(posedge hclk);
    chk("key unsecure", 32'(drd), 32'h0);
    i_fslr_host.scan(1'b1, 4, 32'(`FSLR_IR_DEBUG), dout);
    chk("debug sel open", 32'(dsel), 32'h1);
    ahb(1'b0, A_ST, 32'h0);
    chk("status open", rd, 32'h18);
    $display("test key done");
  endtask

  task automatic t_div();
    rst(16'h0000);
    ahb(1'b1, A_DIV, 32'hC1);
    ahb(1'b0, A_DIV, 32'h0);
    chk("div reg", rd, 32'h41);
    per();
    per();
    chk("period prescaled", 32'(p), 32'd32);
    ahb(1'b1, A_DIV, 32'h03);
    per();
    per();
    chk("period plain", 32'(p), 32'd8);
    $display("test divisor done");
  endtask

  task automatic t_erase();
    // 10 MHz below 12.8 MHz: no prescale, 10M/2/26 gives 192 kHz
    i_fslr_host.scan(1'b1, 4, 32'(`FSLR_IR_LOCKOUT), dout);
    i_fslr_host.scan(1'b0, 7, 32'h19, dout);
    chk("lockout capture", dout, 32'h1);
    repeat (2) @(posedge hclk);
    chk("erase start", 32'(erase), 32'h1);
    i_fslr_host.tap_reset();
    chk("erase abort", 32'(erase), 32'h0);
    ahb(1'b0, A_ST, 32'h0);
    chk("abort status", rd, 32'h1);
    i_fslr_host.scan(1'b1, 4, 32'(`FSLR_IR_LOCKOUT), dout);
    i_fslr_host.scan(1'b0, 7, 32'h19, dout);
    // Host keeps the port in Run-Test/Idle with tck standing still
    repeat (2) @(posedge hclk);
    k = 0;
    while (erase === 1'b1) begin
      @(posedge hclk);
      k++;
    end
    chk("erase length", 32'(k >= 156 && k <= 260), 32'h1);
    repeat (2) @(posedge hclk);
    chk("read enable", 32'(drd), 32'h0);
    ahb(1'b0, A_ST, 32'h0);
    chk("done status", rd, 32'h4);
    i_fslr_host.tap_reset();
    ahb(1'b0, A_ST, 32'h0);
    chk("done sticky", rd, 32'h4);
    rst({14'h0, `FSLR_NV_UNSEC_CODE});  // Chip reset with unsecured strap
    ahb(1'b0, A_ST, 32'h0);
    chk("unsecured boot", rd, 32'h0);
    chk("read enable boot", 32'(drd), 32'h0);
    $display("test erase done");
  endtask

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hresetn = 1'b0;
    nv = 16'h0000;
    n_mismatch = 0;
    checks = 0;
    rst(16'h0000);
    t_boot();
    t_key();
    t_div();
    t_erase();
    end_of_test();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #(3_000_000);
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end
endmodule  // fslr_top_bench
